// [rtl/sfsp_pkg.sv]
// Constants, field layout and carrier types of the flash status block.
// Assumes a command front end that delivers decoded, whole commands.
//
// Contract
// - S0 shows busy for program, erase, status write
// - S1 latch; clear latch refuses all writes
// - Five protect bits S6..S2 pick shielded region
// - Protect bits change only outside hardware lock
// - Chip erase only with empty or full code
// - Mode bits S8..S7 select status protection
// - Mode 00: writable whenever latch set
// - Mode 01, pin low: status locked
// - Mode 01, pin high: writable after latch set
// - Mode 10: locked until power cycle
// - Mode 11: status never writable; the code's reset loads mode 00, as for mode 10
// - S9 quad enable turns pins into data
// - Lock bits S13..S11 set once, never cleared; the code's reset clears them
// - Any lock bit freezes security registers
// - S14 complement combines with protect bits
// - Complement inverts the shielded region
// - Suspend sets erase or program suspend flag
// - Resume, soft reset, power cycle clear flags
// - Write-enable command sets the latch
// - Latch clears on disable, writes, erases
// - Pin low guards protect and mode bits
`default_nettype none

package sfsp_pkg;

  localparam int ADDR_W        = 24;
  localparam int SR_W          = 16;
  localparam int CLK_PERIOD_NS = 8;

  // Status word bit positions
  localparam int WIP_BIT  = 0;
  localparam int WEL_BIT  = 1;
  localparam int BP_LSB   = 2;
  localparam int BP_W     = 5;
  localparam int SRP_LSB  = 7;
  localparam int QE_BIT   = 9;
  localparam int PSUS_BIT = 10;
  localparam int LB_LSB   = 11;
  localparam int LB_W     = 3;
  localparam int CMP_BIT  = 14;
  localparam int ESUS_BIT = 15;

  // Protection mode encodings
  localparam logic [1:0] SRP_SOFT     = 2'h0;
  localparam logic [1:0] SRP_HARD     = 2'h1;
  localparam logic [1:0] SRP_LOCKDOWN = 2'h2;
  localparam logic [1:0] SRP_OTP      = 2'h3;

  // Defaults of the remembered fields
  localparam logic [4:0] BP_RESET  = 5'h00;
  localparam logic [1:0] SRP_RESET = 2'h0;
  localparam logic [2:0] LB_RESET  = 3'h0;

  // Region sizes, one bit wider than an address
  localparam logic [2:0]  BP_CODE_NONE = 3'h0;
  localparam logic [2:0]  BP_CODE_ALL  = 3'h7;
  localparam logic [2:0]  BP_CODE_CAP  = 3'h4;
  localparam logic [24:0] ARRAY_SIZE   = 25'h1000000;
  localparam logic [24:0] LARGE_UNIT   = 25'h0040000;
  localparam logic [24:0] SMALL_UNIT   = 25'h0001000;

  typedef enum logic [3:0] {
    OP_NOP, OP_SET_WEL, OP_CLR_WEL, OP_SR_WRITE, OP_PAGE_PROG,
    OP_SECT_ERASE, OP_BLK_ERASE, OP_CHIP_ERASE, OP_SUSPEND,
    OP_RESUME, OP_RST_ENABLE, OP_RST, OP_SEC_PROG, OP_SEC_ERASE
  } sfsp_op_e;

  typedef enum logic [2:0] {
    KIND_PROG, KIND_SECT_ERASE, KIND_BLK_ERASE, KIND_CHIP_ERASE,
    KIND_SEC_PROG, KIND_SEC_ERASE
  } sfsp_kind_e;

  typedef struct packed {
    logic              valid;
    sfsp_op_e          op;
    logic [ADDR_W-1:0] addr;
    logic [SR_W-1:0]   data;
  } sfsp_cmd_s;

  typedef struct packed {
    logic              start;
    logic              suspend;
    logic              resume;
    logic              abort;
    sfsp_kind_e        kind;
    logic [ADDR_W-1:0] addr;
  } sfsp_eng_s;

endpackage

`default_nettype wire

// [rtl/sfsp_region_decode.sv]
// Decodes whether an array address lies in the shielded region.
// Purely combinational; the caller registers what it drives out.
`default_nettype none

module sfsp_region_decode
  import sfsp_pkg::*;
(
  input  wire logic [BP_W-1:0]   bp_i,
  input  wire logic              cmp_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic                   hit_o
);

  logic [2:0]  code;
  logic [2:0]  shift;
  logic [24:0] size;
  logic [24:0] addr_w;
  logic        plain;

  // Ordinary region first, then the complement flips it
  always_comb begin
    code   = bp_i[2:0];
    addr_w = {1'b0, addr_i};
    shift  = 3'h0;
    size   = SMALL_UNIT;
    plain  = 1'b0;
    if (code == BP_CODE_NONE) begin
      plain = 1'b0;
    end else if (code == BP_CODE_ALL) begin
      plain = 1'b1;
    end else begin
      // Small slices stop growing at 32 KB
      if (bp_i[4] && code >= BP_CODE_CAP) begin
        shift = 3'h3;
      end else begin
        shift = code - 3'h1;
      end
      size = (bp_i[4] ? SMALL_UNIT : LARGE_UNIT) << shift;
      if (bp_i[3]) begin
        plain = addr_w < size;
      end else begin
        plain = addr_w >= (ARRAY_SIZE - size);
      end
    end
    hit_o = plain ^ cmp_i;
  end

endmodule

`default_nettype wire

// [rtl/sfsp_status_prot.sv]
// Status word and write protection of a serial NOR flash.
// Assumes a same-clock front end delivering one decoded command per
// valid pulse, and an array engine that pulses eng_done_i when done.
`default_nettype none

module sfsp_status_prot
  import sfsp_pkg::*;
#(
  parameter int SR_WRITE_TIME_NS = 1000
)
(
  input  wire logic      ref_clk_i,
  input  wire logic      rst_n_i,
  input  wire sfsp_cmd_s cmd_i,
  input  wire logic      wp_n_i,
  input  wire logic      eng_done_i,
  output logic           [SR_W-1:0] status_o,
  output sfsp_eng_s      eng_o,
  output logic           cmd_reject_o,
  output logic           quad_mode_o
);

  // Status write busy time, rounded up, at least one cycle
  localparam int SR_WRITE_CYC_RAW =
    (SR_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SR_WRITE_CYC =
    (SR_WRITE_CYC_RAW < 1) ? 1 : SR_WRITE_CYC_RAW;
  localparam int CNT_W = $clog2(SR_WRITE_CYC + 1);
  localparam logic [CNT_W-1:0] SR_CNT_LOAD = CNT_W'(SR_WRITE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  typedef enum logic [1:0] {
    ST_IDLE, ST_SR_BUSY, ST_OP_BUSY, ST_SUSPENDED
  } sfsp_state_e;

  // Chip erase allowed only with nothing or everything coded
  function automatic logic chip_erase_ok(input logic [BP_W-1:0] bp,
                                         input logic cmp);
    chip_erase_ok = (bp[2:0] == BP_CODE_NONE && !cmp) ||
                    (bp[2:0] == BP_CODE_ALL && cmp);
  endfunction

  // Erase operations set the erase flag when suspended
  function automatic logic is_erase(input sfsp_kind_e k);
    is_erase = (k != KIND_PROG) && (k != KIND_SEC_PROG);
  endfunction

  // Reset release and pin synchronisers
  logic rst_meta_reg;
  logic rst_sync_n;
  logic wp_meta_reg;
  logic wp_sync_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // The pin comes from outside, so it passes two flops first
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wp_meta_reg <= 1'b1;
      wp_sync_reg <= 1'b1;
    end else begin
      wp_meta_reg <= wp_n_i;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  // Control state
  sfsp_state_e       state_reg, state_next;
  logic              wel_reg, wel_next;
  logic [BP_W-1:0]   bp_reg, bp_next;
  logic [1:0]        srp_reg, srp_next;
  logic              qe_reg, qe_next;
  logic [LB_W-1:0]   lb_reg, lb_next;
  logic              cmp_reg, cmp_next;
  logic              esus_reg, esus_next;
  logic              psus_reg, psus_next;
  logic              armed_reg, armed_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  sfsp_kind_e        kind_reg, kind_next;
  logic [SR_W-1:0]   status_reg, status_next;
  sfsp_eng_s         eng_reg, eng_next;
  logic              reject_reg, reject_next;

  logic wp_eff;
  logic sr_write_ok;
  logic region_hit;
  logic wip_next;

  sfsp_region_decode u_region (
    .bp_i   (bp_reg),
    .cmp_i  (cmp_reg),
    .addr_i (cmd_i.addr),
    .hit_o  (region_hit)
  );

  // With quad mode on the pin carries data and no longer guards
  assign wp_eff = qe_reg ? 1'b1 : wp_sync_reg;

  // Status writability by protection mode
  always_comb begin
    case (srp_reg)
      SRP_SOFT:     sr_write_ok = wel_reg;
      SRP_HARD:     sr_write_ok = wel_reg && wp_eff;
      SRP_LOCKDOWN: sr_write_ok = 1'b0;
      SRP_OTP:      sr_write_ok = 1'b0;
      default:      sr_write_ok = 1'b0;
    endcase
  end

  // Next-state logic for the command sequencer and status fields
  always_comb begin
    state_next  = state_reg;
    wel_next    = wel_reg;
    bp_next     = bp_reg;
    srp_next    = srp_reg;
    qe_next     = qe_reg;
    lb_next     = lb_reg;
    cmp_next    = cmp_reg;
    esus_next   = esus_reg;
    psus_next   = psus_reg;
    armed_next  = armed_reg;
    cnt_next    = cnt_reg;
    kind_next   = kind_reg;
    reject_next = 1'b0;
    eng_next    = eng_reg;
    eng_next.start   = 1'b0;
    eng_next.suspend = 1'b0;
    eng_next.resume  = 1'b0;
    eng_next.abort   = 1'b0;

    // Completion of the busy phases: timed for a status write, on eng_done_i for an operation
    case (state_reg)
      ST_SR_BUSY: begin
        if (cnt_reg == CNT_ZERO) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      ST_OP_BUSY: begin
        if (eng_done_i) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
      end
    endcase

    if (cmd_i.valid) begin
      // Reset must directly follow its enable command
      armed_next = (cmd_i.op == OP_RST_ENABLE);
      case (cmd_i.op)
        OP_SET_WEL: begin
          if (state_reg == ST_IDLE || state_reg == ST_SUSPENDED) begin
            wel_next = 1'b1;
          end
        end
        OP_CLR_WEL: begin
          if (state_reg == ST_IDLE || state_reg == ST_SUSPENDED) begin
            wel_next = 1'b0;
          end
        end
        OP_SR_WRITE: begin
          if (state_reg != ST_IDLE || !wel_reg) begin
            reject_next = 1'b1;
          end else begin
            wel_next = 1'b0;
            if (sr_write_ok) begin
              bp_next   = cmd_i.data[BP_LSB +: BP_W];
              srp_next  = cmd_i.data[SRP_LSB +: 2];
              qe_next   = cmd_i.data[QE_BIT];
              lb_next   = lb_reg | cmd_i.data[LB_LSB +: LB_W];
              cmp_next  = cmd_i.data[CMP_BIT];
              cnt_next  = SR_CNT_LOAD;
              state_next = ST_SR_BUSY;
            end else begin
              reject_next = 1'b1;
            end
          end
        end
        OP_PAGE_PROG, OP_SECT_ERASE, OP_BLK_ERASE, OP_CHIP_ERASE,
        OP_SEC_PROG, OP_SEC_ERASE: begin
          if (state_reg != ST_IDLE || !wel_reg) begin
            reject_next = 1'b1;
          end else begin
            wel_next = 1'b0;
            case (cmd_i.op)
              OP_PAGE_PROG:  kind_next = KIND_PROG;
              OP_SECT_ERASE: kind_next = KIND_SECT_ERASE;
              OP_BLK_ERASE:  kind_next = KIND_BLK_ERASE;
              OP_CHIP_ERASE: kind_next = KIND_CHIP_ERASE;
              OP_SEC_PROG:   kind_next = KIND_SEC_PROG;
              default:       kind_next = KIND_SEC_ERASE;
            endcase
            if (cmd_i.op == OP_CHIP_ERASE) begin
              reject_next = !chip_erase_ok(bp_reg, cmp_reg);
            end else if (cmd_i.op == OP_SEC_PROG ||
                         cmd_i.op == OP_SEC_ERASE) begin
              reject_next = (lb_reg != LB_RESET);
            end else begin
              reject_next = region_hit;
            end
            // A dropped operation never starts the engine
            if (!reject_next) begin
              state_next     = ST_OP_BUSY;
              eng_next.start = 1'b1;
              eng_next.kind  = kind_next;
              eng_next.addr  = cmd_i.addr;
            end
          end
        end
        OP_SUSPEND: begin
          if (state_reg == ST_OP_BUSY && !eng_done_i &&
              kind_reg != KIND_CHIP_ERASE) begin
            if (is_erase(kind_reg)) begin
              esus_next = 1'b1;
            end else begin
              psus_next = 1'b1;
            end
            eng_next.suspend = 1'b1;
            state_next = ST_SUSPENDED;
          end else begin
            reject_next = 1'b1;
          end
        end
        OP_RESUME: begin
          if (state_reg == ST_SUSPENDED) begin
            esus_next = 1'b0;
            psus_next = 1'b0;
            eng_next.resume = 1'b1;
            state_next = ST_OP_BUSY;
          end else begin
            reject_next = 1'b1;
          end
        end
        OP_RST: begin
          if (armed_reg) begin
            // Soft reset drops a suspended operation for good
            esus_next = 1'b0;
            psus_next = 1'b0;
            wel_next  = 1'b0;
            if (state_reg == ST_SUSPENDED) begin
              eng_next.abort = 1'b1;
              state_next = ST_IDLE;
            end
          end else begin
            reject_next = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    wip_next = (state_next == ST_SR_BUSY) ||
               (state_next == ST_OP_BUSY);
    status_next = '0;
    status_next[WIP_BIT]           = wip_next;
    status_next[WEL_BIT]           = wel_next;
    status_next[BP_LSB +: BP_W]    = bp_next;
    status_next[SRP_LSB +: 2]      = srp_next;
    status_next[QE_BIT]            = qe_next;
    status_next[PSUS_BIT]          = psus_next;
    status_next[LB_LSB +: LB_W]    = lb_next;
    status_next[CMP_BIT]           = cmp_next;
    status_next[ESUS_BIT]          = esus_next;
  end

  // Register stage; reset stands for a power cycle
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg  <= ST_IDLE;
      wel_reg    <= 1'b0;
      bp_reg     <= BP_RESET;
      srp_reg    <= SRP_RESET;
      qe_reg     <= 1'b0;
      lb_reg     <= LB_RESET;
      cmp_reg    <= 1'b0;
      esus_reg   <= 1'b0;
      psus_reg   <= 1'b0;
      armed_reg  <= 1'b0;
      cnt_reg    <= CNT_ZERO;
      kind_reg   <= KIND_PROG;
      status_reg <= '0;
      eng_reg    <= '0;
      reject_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      wel_reg    <= wel_next;
      bp_reg     <= bp_next;
      srp_reg    <= srp_next;
      qe_reg     <= qe_next;
      lb_reg     <= lb_next;
      cmp_reg    <= cmp_next;
      esus_reg   <= esus_next;
      psus_reg   <= psus_next;
      armed_reg  <= armed_next;
      cnt_reg    <= cnt_next;
      kind_reg   <= kind_next;
      status_reg <= status_next;
      eng_reg    <= eng_next;
      reject_reg <= reject_next;
    end
  end

  assign status_o     = status_reg;
  assign eng_o        = eng_reg;
  assign cmd_reject_o = reject_reg;
  assign quad_mode_o  = status_reg[QE_BIT];

endmodule

`default_nettype wire

// [testbench/sfsp_status_prot_checker.sv]
// Port checks of the status and protection block.
// Bound to the top module; sees its ports only.
`default_nettype none
module sfsp_status_prot_checker
  import sfsp_pkg::*;
#(
  parameter int SR_WRITE_TIME_NS = 1000
)
(
  input wire logic            ref_clk_i,
  input wire logic            rst_n_i,
  input wire sfsp_cmd_s       cmd_i,
  input wire logic            wp_n_i,
  input wire logic            eng_done_i,
  input wire logic [SR_W-1:0] status_o,
  input wire sfsp_eng_s       eng_o,
  input wire logic            cmd_reject_o,
  input wire logic            quad_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Two cycles of slack on the busy time of a status write
  localparam int SRC = SR_WRITE_TIME_NS / CLK_PERIOD_NS + 2;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Pin seen low long enough to pass its two flops
  sequence wp_low_s;
    !wp_n_i [*4];
  endsequence
  sequence sr_take_s;
    cmd_i.valid && cmd_i.op == OP_SR_WRITE && status_o[1:0] == 2'h2
      && status_o[8:7] == SRP_SOFT && !status_o[15] && !status_o[10];
  endsequence
  sequence busy_done_s;
    status_o[1:0] == 2'h1 ##[1:SRC] !status_o[0];
  endsequence

  wel_set_a: assert property (
    cmd_i.valid && cmd_i.op == OP_SET_WEL |=> status_o[WEL_BIT])
    else $error("latch not set");
  no_latch_a: assert property (
    cmd_i.valid && !status_o[0] && !status_o[1] && cmd_i.op inside
    {OP_SR_WRITE, OP_PAGE_PROG, OP_SECT_ERASE, OP_BLK_ERASE,
     OP_CHIP_ERASE} |=> cmd_reject_o && !eng_o.start && !status_o[0])
    else $error("write taken without latch");
  chip_guard_a: assert property (
    cmd_i.valid && cmd_i.op == OP_CHIP_ERASE && status_o[1:0] == 2'h2
    && !((status_o[4:2] == 3'h0 && !status_o[CMP_BIT])
    || (status_o[4:2] == 3'h7 && status_o[CMP_BIT]))
    |=> cmd_reject_o && !eng_o.start && !status_o[0])
    else $error("chip erase not skipped");
  hw_lock_a: assert property (
    wp_low_s ##0 (cmd_i.valid && cmd_i.op == OP_SR_WRITE
    && status_o[8:7] == SRP_HARD && !status_o[QE_BIT])
    |=> cmd_reject_o && $stable(status_o[8:2]))
    else $error("status written under pin lock");
  mode_lock_a: assert property (
    cmd_i.valid && cmd_i.op == OP_SR_WRITE && status_o[8]
    |=> cmd_reject_o && $stable(status_o[8:2]))
    else $error("status written under mode lock");
  lock_keep_a: assert property (
    ($past(status_o[13:11]) & ~status_o[13:11]) == 3'h0)
    else $error("lock bit cleared");
  sr_busy_a: assert property (
    sr_take_s |=> busy_done_s)
    else $error("status write busy wrong");
  susp_flag_a: assert property (
    eng_o.suspend |-> status_o[ESUS_BIT] != status_o[PSUS_BIT])
    else $error("suspend flag wrong");
  resume_clr_a: assert property (
    cmd_i.valid && cmd_i.op == OP_RESUME && (status_o[15] || status_o[10])
    |=> !status_o[15] && !status_o[10] && eng_o.resume)
    else $error("resume left flag");
  start_info_a: assert property (
    cmd_i.valid && cmd_i.op == OP_PAGE_PROG && status_o[1:0] == 2'h2
    && !status_o[15] && !status_o[10]
    |=> (cmd_reject_o != eng_o.start) && (cmd_reject_o
    || (eng_o.kind == KIND_PROG && eng_o.addr == $past(cmd_i.addr))))
    else $error("program start wrong");
  abort_clear_a: assert property (
    eng_o.abort |-> status_o[1:0] == 2'h0
    && !status_o[15] && !status_o[10])
    else $error("abort left state");
endmodule

bind sfsp_status_prot sfsp_status_prot_checker #(
  .SR_WRITE_TIME_NS(SR_WRITE_TIME_NS)
) u_sfsp_status_prot_checker (
  .ref_clk_i    (ref_clk_i),
  .rst_n_i      (rst_n_i),
  .cmd_i        (cmd_i),
  .wp_n_i       (wp_n_i),
  .eng_done_i   (eng_done_i),
  .status_o     (status_o),
  .eng_o        (eng_o),
  .cmd_reject_o (cmd_reject_o),
  .quad_mode_o  (quad_mode_o)
);
`default_nettype wire

// [testbench/sfsp_engine_model.sv]
// Array engine model: answers each start that is not aborted with a done pulse.
// Assumes the block's clock; slow_i stretches runs for suspends.
`default_nettype none
module sfsp_engine_model
  import sfsp_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  input  wire sfsp_eng_s eng_i,
  input  wire logic      slow_i,
  output logic           done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       run;
  logic [7:0] cnt;

  // Suspend and abort freeze the run; resume goes on from the count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run    <= 1'b0;
      cnt    <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (eng_i.start) begin
        run <= 1'b1;
        cnt <= slow_i ? 8'h20 : 8'h02;
      end else if (eng_i.suspend || eng_i.abort) begin
        run <= 1'b0;
      end else if (eng_i.resume) begin
        run <= 1'b1;
      end else if (run && cnt == 8'h00) begin
        run    <= 1'b0;
        done_o <= 1'b1;
      end else if (run) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/serial_flash_status_protection_test.sv]
// Self-checking bench of the status and protection block.
// Bench acts as the command front end; engine model answers starts.
`default_nettype none
`define CHK(nm, got, ex) begin checked++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module serial_flash_status_protection_test
  import sfsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        rj;
    logic [15:0] m;
    logic [15:0] v;
  } sfsp_note_s;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wp_n = 1'b0;
  logic        slow = 1'b0;
  logic        done, quad, rej;
  logic        tk = 1'b0;
  logic [15:0] status, img;
  logic [23:0] a;
  sfsp_cmd_s   req = '0;
  sfsp_eng_s   eng;
  sfsp_note_s  q[$];
  sfsp_note_s  n;
  int unsigned sd;
  int          checked = 0;
  int          n_mismatch = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  // Short write time keeps status writes at two cycles
  sfsp_status_prot #(
    .SR_WRITE_TIME_NS(16)
  ) u_sfsp_status_prot (
    .ref_clk_i    (clk),
    .rst_n_i      (rst_n),
    .cmd_i        (req),
    .wp_n_i       (wp_n),
    .eng_done_i   (done),
    .status_o     (status),
    .eng_o        (eng),
    .cmd_reject_o (rej),
    .quad_mode_o  (quad)
  );
  sfsp_engine_model u_sfsp_engine_model (
    .clk_i   (clk),
    .rst_n_i (rst_n),
    .eng_i   (eng),
    .slow_i  (slow),
    .done_o  (done)
  );

  // Answer lands on the taking edge; the reject pulse is gone one edge
  // later, so look at the falling edge right after taking
  always @(posedge clk) tk <= req.valid;
  always @(negedge clk) begin
    if (tk) begin
      n = q.pop_front();
      `CHK("reject", rej, n.rj)
      `CHK("status", status & n.m, n.v)
    end
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One command cycle, then one idle cycle, noting the answer
  task automatic cmd(input sfsp_op_e op, input logic [23:0] ad,
                     input logic [15:0] d, input logic rj,
                     input logic [15:0] m, input logic [15:0] v);
    q.push_back({rj, m, v});
    req <= {1'b1, op, ad, d};
    @(negedge clk);
    req.valid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic write_enable_latch();
    cmd(OP_SET_WEL, '0, '0, 1'b0, 16'h0002, 16'h0002);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (status[0] !== 1'b0 && k < 300) begin
      @(negedge clk);
      k++;
    end
    `CHK("idle", status[0], 1'b0)
  endtask

  // Refused writes clear the latch and keep the stored image
  task automatic srw(input logic [15:0] d, input logic ok);
    write_enable_latch();
    if (ok) img = (d & 16'h7bfc) | (img & 16'h3800);
    cmd(OP_SR_WRITE, '0, d, !ok, 16'h7bff, img | {15'h0, ok});
    wait_idle();
  endtask

  task automatic pp(input sfsp_op_e op, input logic [23:0] ad,
                    input logic rj);
    write_enable_latch();
    cmd(op, ad, '0, rj, 16'h0003, {15'h0, !rj});
    wait_idle();
  endtask

  task automatic power_cycle();
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    img = 16'h0;
    `CHK("reset", status, 16'h0)
  endtask

  // Main sequence
  initial begin
    sd = $urandom(45116);
    img = 16'h0;
    power_cycle();
    cmd(OP_SR_WRITE, '0, 16'h0004, 1'b1, 16'h0003, 16'h0);
    write_enable_latch();
    cmd(OP_CLR_WEL, '0, '0, 1'b0, 16'h0002, 16'h0);
    srw(16'h0004, 1'b1);
    for (int i = 0; i < 8; i++) begin
      a = 24'($urandom);
      if (i[0]) a[23:18] = 6'h3f;
      pp(OP_PAGE_PROG, a, a >= 24'hfc0000);
    end
    pp(OP_SECT_ERASE, 24'hfc1000, 1'b1);
    pp(OP_BLK_ERASE, 24'h010000, 1'b0);
    pp(OP_CHIP_ERASE, '0, 1'b1);
    srw(16'h4000, 1'b1);
    pp(OP_PAGE_PROG, 24'h000000, 1'b1);
    pp(OP_CHIP_ERASE, '0, 1'b1);
    srw(16'h4064, 1'b1);
    pp(OP_PAGE_PROG, 24'h000ff0, 1'b0);
    pp(OP_PAGE_PROG, 24'h001000, 1'b1);
    srw(16'h401c, 1'b1);
    pp(OP_CHIP_ERASE, '0, 1'b0);
    // Slow engine so that suspends land mid-operation
    slow = 1'b1;
    write_enable_latch();
    cmd(OP_SECT_ERASE, 24'h123000, '0, 1'b0, 16'h0003, 16'h0001);
    cmd(OP_SUSPEND, '0, '0, 1'b0, 16'h8401, 16'h8000);
    cmd(OP_RESUME, '0, '0, 1'b0, 16'h8401, 16'h0001);
    wait_idle();
    write_enable_latch();
    cmd(OP_PAGE_PROG, 24'h000100, '0, 1'b0, 16'h0003, 16'h0001);
    cmd(OP_SUSPEND, '0, '0, 1'b0, 16'h8401, 16'h0400);
    cmd(OP_RST_ENABLE, '0, '0, 1'b0, 16'h0400, 16'h0400);
    cmd(OP_RST, '0, '0, 1'b0, 16'h8403, 16'h0);
    cmd(OP_RESUME, '0, '0, 1'b1, 16'h8401, 16'h0);
    slow = 1'b0;
    srw(16'h501c, 1'b1);
    srw(16'h401c, 1'b1);
    pp(OP_SEC_PROG, 24'h001000, 1'b1);
    pp(OP_SEC_ERASE, 24'h001000, 1'b1);
    srw(16'h521c, 1'b1);
    `CHK("quad", quad, 1'b1)
    // Pin is tied low here, so once mode 01 is set the next write is refused
    srw(16'h501c, 1'b1);
    srw(16'h509c, 1'b1);
    srw(16'h501c, 1'b0);
    wp_n = 1'b1;
    repeat (3) @(negedge clk);
    srw(16'h5098, 1'b1);
    srw(16'h5118, 1'b1);
    srw(16'h5018, 1'b0);
    power_cycle();
    srw(16'h0180, 1'b1);
    srw(16'h0000, 1'b0);
    end_of_test();
  end

  // The run takes a few hundred cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
